// File: verilog/apg_defs.vh
// Constants for the two-axis profile generator
// Overview of operation
// - Target absolute or relative, speed, ramp rates
// - Begin builds trapezoid or triangle profile per axis
// - Brake early so axis stops on target
// - One new commanded position every sample period
// - Complete at last command; next move accepted
// - Begin names axes; no axis means all
// - Speed, ramp-up change anytime; host holds rest
// - Halt anytime, ramps down to rest
// - Increment extends target without begin, same direction
// - Idle increment acts as relative move plus begin
// - Separate profile-done and in-position wait flags
// - Jog sign sets direction; ramp and hold speed
// - Jog speed change ramps, never steps
// - Jog increment jumps commanded position at the next sample
// - Jog integrates velocity into position each sample
// - At-speed flag once jog reaches commanded speed
// - Measured velocity averaged over quarter-second window
// - Read back rates, speed, distance, stop position
// - Smoothing time constant shapes both modes
// - Commands touch only the axes addressed
`ifndef APG_DEFS_VH
`define APG_DEFS_VH
`define APG_CLK_HZ         50000000
`define APG_SAMPLE_NS      1000000
`define APG_SAMPLE_CYC     (`APG_SAMPLE_NS * (`APG_CLK_HZ / 1000000) / 1000)
`define APG_TV_WINDOW_MS   250
`define APG_TV_SAMPLES     (`APG_TV_WINDOW_MS * 1000000 / `APG_SAMPLE_NS)
`define APG_TV_SCALE       2
`define APG_FRAC           8
`define APG_OP_ABS         4'h1
`define APG_OP_REL         4'h2
`define APG_OP_CRUISE      4'h3
`define APG_OP_UP          4'h4
`define APG_OP_DOWN        4'h5
`define APG_OP_JOG         4'h6
`define APG_OP_SMOOTH      4'h7
`define APG_OP_BEGIN       4'h8
`define APG_OP_HALT        4'h9
`define APG_OP_INCR        4'ha
`define APG_RB_UP          3'h0
`define APG_RB_DOWN        3'h1
`define APG_RB_SPEED       3'h2
`define APG_RB_REL         3'h3
`define APG_RB_STOP        3'h4
`define APG_RB_VEL         3'h5
`define APG_INPOS_TOL      32'h0000_0004
`endif

// File: verilog/apg_axis_profile_generator.v
// Two-axis positioning and jog profile generator
`timescale 1ns/10ps
`include "apg_defs.vh"
module apg_axis_profile_generator #(
  parameter SAMPLE_CYC = `APG_SAMPLE_CYC,
  parameter TV_SAMPLES = `APG_TV_SAMPLES,
  parameter INPOS_TOL  = `APG_INPOS_TOL
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_op,
  input  wire [1:0]  cmd_axes,
  input  wire [31:0] cmd_val_x,
  input  wire [31:0] cmd_val_y,
  input  wire [31:0] actual_pos_x,
  input  wire [31:0] actual_pos_y,
  input  wire        rb_axis,
  input  wire [2:0]  rb_sel,
  output wire [31:0] pos_cmd_x,
  output wire [31:0] pos_cmd_y,
  output wire [31:0] measured_velocity_x,
  output wire [31:0] measured_velocity_y,
  output wire [1:0]  profile_done_wait,
  output wire [1:0]  in_position_wait,
  output wire [1:0]  at_speed_wait,
  output wire [1:0]  increment_reject,
  output wire        sample_tick,
  output wire [31:0] rb_data
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_POS  = 4'b0010;
  localparam ST_JOG  = 4'b0100;
  localparam ST_HALT = 4'b1000;
  localparam FR      = `APG_FRAC;

  reg  [31:0] div_q;
  reg         tick_q;
  reg  [15:0] win_q;
  reg         win_tick_q;
  reg  [31:0] rb_q;
  wire [63:0] pos_all;
  wire [63:0] vel_all;
  wire [63:0] rb_all;

  // Move speed toward goal by one ramp step, never past it
  function [23:0] apg_ramp;
    input [23:0] v;
    input [23:0] goal;
    input [23:0] up;
    input [23:0] dn;
    reg   [24:0] s;
    begin
      s = {1'b0, v} + {1'b0, up};
      if (v < goal)
        apg_ramp = (s[24] || s[23:0] >= goal) ? goal : s[23:0];
      else if (v > goal)
        apg_ramp = ((v - goal) <= dn) ? goal : (v - dn);
      else
        apg_ramp = goal;
    end
  endfunction

  // True when stopping distance v^2/(2d) covers what is left
  function apg_brake;
    input [23:0] v;
    input [23:0] dn;
    input [39:0] rem;
    reg   [63:0] lhs;
    reg   [63:0] rhs;
    begin
      lhs = {40'h0, v} * {40'h0, v};
      rhs = {40'h0, dn} * {24'h0, rem};
      apg_brake = (lhs >= {rhs[62:0], 1'b0});
    end
  endfunction

  // Sample period divider
  always @(posedge clock) begin
    if (reset) begin
      div_q      <= 32'h0;
      tick_q     <= 1'b0;
      win_q      <= 16'h0;
      win_tick_q <= 1'b0;
    end else begin
      tick_q     <= 1'b0;
      win_tick_q <= 1'b0;
      if (div_q == SAMPLE_CYC - 1) begin
        div_q  <= 32'h0;
        tick_q <= 1'b1;
        if (win_q == TV_SAMPLES - 1) begin
          win_q      <= 16'h0;
          win_tick_q <= 1'b1;
        end else begin
          win_q <= win_q + 16'h1;
        end
      end else begin
        div_q <= div_q + 32'h1;
      end
    end
  end

  genvar a;
  generate
    for (a = 0; a < 2; a = a + 1) begin : g_axis
      wire [31:0] val = (a == 0) ? cmd_val_x : cmd_val_y;
      wire [31:0] act = (a == 0) ? actual_pos_x : actual_pos_y;
      wire        hit = cmd_valid & cmd_axes[a];
      wire        go  = cmd_valid & (cmd_op == `APG_OP_BEGIN) &
                        (cmd_axes[a] | (cmd_axes == 2'b00));
      reg  [3:0]  state_q;
      reg  [31:0] abs_q;
      reg  [31:0] rel_q;
      reg         use_rel_q;
      reg         jogmode_q;
      reg  [23:0] cruise_q;
      reg  [23:0] up_q;
      reg  [23:0] dn_q;
      reg  [31:0] jog_q;
      reg  [3:0]  smooth_q;
      reg  [39:0] tgt_q;
      reg  [39:0] pos_q;
      reg  [39:0] out_q;
      reg  [23:0] vmag_q;
      reg         dir_q;
      reg  [31:0] stop_q;
      reg         rej_q;
      reg  [31:0] tvbase_q;
      reg  [31:0] tv_q;
      reg  [31:0] rbw;

      wire [39:0] rem     = tgt_q - pos_q;
      wire [39:0] rem_abs = rem[39] ? (40'h0 - rem) : rem;
      wire [31:0] jneg    = 32'h0 - jog_q;
      wire [23:0] jmag    = jog_q[31] ? jneg[23:0] : jog_q[23:0];
      wire        brake   = apg_brake(vmag_q, dn_q, rem_abs);
      wire [23:0] v_pos   = apg_ramp(vmag_q, brake ? 24'h0 : cruise_q,
                                     up_q, dn_q);
      wire        jflip   = (jog_q[31] != dir_q) && (vmag_q != 24'h0);
      wire [23:0] v_jog   = apg_ramp(vmag_q, jflip ? 24'h0 : jmag,
                                     up_q, dn_q);
      wire [23:0] v_halt  = apg_ramp(vmag_q, 24'h0, up_q, dn_q);
      wire [39:0] diff    = pos_q - out_q;
      wire [39:0] dstep   = $signed(diff) >>> smooth_q;
      wire [39:0] inc_fx  = {val, 8'h00};
      wire [31:0] out_int = out_q[39:FR];
      wire [31:0] perr    = act - out_int;
      wire [31:0] perr_a  = perr[31] ? (32'h0 - perr) : perr;
      wire        idle    = (state_q == ST_IDLE);
      wire        done    = idle && (out_q == pos_q);

      always @(posedge clock) begin
        if (reset) begin
          state_q   <= ST_IDLE;
          abs_q     <= 32'h0;
          rel_q     <= 32'h0;
          use_rel_q <= 1'b0;
          jogmode_q <= 1'b0;
          cruise_q  <= 24'h0;
          up_q      <= 24'h0;
          dn_q      <= 24'h0;
          jog_q     <= 32'h0;
          smooth_q  <= 4'h0;
          tgt_q     <= 40'h0;
          pos_q     <= 40'h0;
          out_q     <= 40'h0;
          vmag_q    <= 24'h0;
          dir_q     <= 1'b0;
          stop_q    <= 32'h0;
          rej_q     <= 1'b0;
          tvbase_q  <= 32'h0;
          tv_q      <= 32'h0;
        end else begin
          rej_q <= 1'b0;
          if (win_tick_q) begin
            tv_q     <= (act - tvbase_q) << `APG_TV_SCALE;
            tvbase_q <= act;
          end
          if (tick_q) begin
            // Smoothing lags the raw trajectory; done waits for it
            if (dstep == 40'h0)
              out_q <= pos_q;
            else
              out_q <= out_q + dstep;
            case (state_q)
              ST_IDLE: begin
                vmag_q <= 24'h0;
              end
              ST_POS: begin
                if (vmag_q == 24'h0)
                  dir_q <= rem[39];
                if (rem_abs <= {16'h0, v_pos} ||
                    (brake && v_pos == 24'h0)) begin
                  pos_q   <= tgt_q;
                  vmag_q  <= 24'h0;
                  stop_q  <= tgt_q[39:FR];
                  state_q <= ST_IDLE;
                end else begin
                  vmag_q <= v_pos;
                  pos_q  <= rem[39] ? pos_q - {16'h0, v_pos}
                                    : pos_q + {16'h0, v_pos};
                end
              end
              ST_JOG: begin
                vmag_q <= v_jog;
                if (vmag_q == 24'h0)
                  dir_q <= jog_q[31];
                pos_q <= (vmag_q == 24'h0 ? jog_q[31] : dir_q)
                         ? pos_q - {16'h0, v_jog}
                         : pos_q + {16'h0, v_jog};
              end
              ST_HALT: begin
                vmag_q <= v_halt;
                pos_q  <= dir_q ? pos_q - {16'h0, v_halt}
                                : pos_q + {16'h0, v_halt};
                if (v_halt == 24'h0) begin
                  stop_q  <= pos_q[39:FR];
                  state_q <= ST_IDLE;
                end
              end
              default: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
          if (hit) begin
            case (cmd_op)
              `APG_OP_ABS: begin
                abs_q     <= val;
                use_rel_q <= 1'b0;
                jogmode_q <= 1'b0;
              end
              `APG_OP_REL: begin
                rel_q     <= val;
                use_rel_q <= 1'b1;
                jogmode_q <= 1'b0;
              end
              `APG_OP_CRUISE: cruise_q <= val[23:0];
              `APG_OP_UP:     up_q     <= val[23:0];
              `APG_OP_DOWN:   dn_q     <= val[23:0];
              `APG_OP_SMOOTH: smooth_q <= val[3:0];
              `APG_OP_JOG: begin
                jog_q     <= val;
                jogmode_q <= 1'b1;
              end
              `APG_OP_HALT: begin
                if (state_q == ST_POS || state_q == ST_JOG)
                  state_q <= ST_HALT;
              end
              `APG_OP_INCR: begin
                if (idle) begin
                  rel_q     <= val;
                  use_rel_q <= 1'b1;
                  jogmode_q <= 1'b0;
                  tgt_q     <= pos_q + inc_fx;
                  state_q   <= ST_POS;
                end else if (state_q == ST_JOG) begin
                  pos_q <= pos_q + inc_fx;
                end else if (state_q == ST_POS) begin
                  // Keep moving if the last step lands this same tick
                  if (vmag_q == 24'h0 || val[31] == dir_q) begin
                    tgt_q   <= tgt_q + inc_fx;
                    state_q <= ST_POS;
                  end else begin
                    rej_q <= 1'b1;
                  end
                end
              end
              default: begin
                rej_q <= 1'b0;
              end
            endcase
          end
          if (go && idle) begin
            if (jogmode_q) begin
              state_q <= ST_JOG;
            end else begin
              state_q <= ST_POS;
              tgt_q   <= use_rel_q ? {stop_q + rel_q, 8'h00}
                                   : {abs_q, 8'h00};
            end
          end
        end
      end

      always @* begin
        case (rb_sel)
          `APG_RB_UP:    rbw = {8'h00, up_q};
          `APG_RB_DOWN:  rbw = {8'h00, dn_q};
          `APG_RB_SPEED: rbw = jogmode_q ? jog_q : {8'h00, cruise_q};
          `APG_RB_REL:   rbw = rel_q;
          `APG_RB_STOP:  rbw = stop_q;
          `APG_RB_VEL:   rbw = tv_q;
          default:       rbw = 32'h0;
        endcase
      end

      assign pos_all[a*32 +: 32] = out_int;
      assign vel_all[a*32 +: 32] = tv_q;
      assign rb_all[a*32 +: 32]  = rbw;
      assign profile_done_wait[a] = done;
      assign in_position_wait[a]  = done &&
                                    (perr_a <= INPOS_TOL);
      assign at_speed_wait[a]     = (state_q == ST_JOG) &&
                                    (vmag_q == jmag) &&
                                    (dir_q == jog_q[31]);
      assign increment_reject[a]  = rej_q;
    end
  endgenerate

  always @(posedge clock) begin
    if (reset)
      rb_q <= 32'h0;
    else
      rb_q <= rb_axis ? rb_all[63:32] : rb_all[31:0];
  end

  assign pos_cmd_x           = pos_all[31:0];
  assign pos_cmd_y           = pos_all[63:32];
  assign measured_velocity_x = vel_all[31:0];
  assign measured_velocity_y = vel_all[63:32];
  assign sample_tick         = tick_q;
  assign rb_data             = rb_q;
endmodule // apg_axis_profile_generator

// File: testbench/apg_amp_model.sv
// Amplifier and encoder stand-in trailing the commanded position
`timescale 1ns/10ps
module apg_amp_model (
  input  wire        clock,
  input  wire [31:0] pos_cmd,
  output reg  [31:0] actual_pos
);
  initial actual_pos = 32'h0;
  // One count per clock, so the motor lags the profile on purpose
  always @(posedge clock) begin
    if ($signed(pos_cmd - actual_pos) > 0)
      actual_pos <= actual_pos + 32'h1;
    else if (pos_cmd != actual_pos)
      actual_pos <= actual_pos - 32'h1;
  end
endmodule // apg_amp_model

// File: testbench/apg_axis_profile_generator_assertions.sv
// Port checker for the profile generator, X axis
`timescale 1ns/10ps
module apg_checker #(
  parameter SAMPLE_CYC = 8,
  parameter INPOS_TOL  = 4
) (
  input wire        clock,
  input wire        reset,
  input wire        cmd_valid,
  input wire [3:0]  cmd_op,
  input wire [1:0]  cmd_axes,
  input wire [31:0] actual_pos_x,
  input wire [31:0] pos_cmd_x,
  input wire [1:0]  profile_done_wait,
  input wire [1:0]  in_position_wait,
  input wire [1:0]  at_speed_wait,
  input wire [1:0]  increment_reject,
  input wire        sample_tick
);
  reg  [31:0] gap_q;
  reg         seen_q;
  wire [31:0] err = pos_cmd_x - actual_pos_x;
  wire [31:0] mag = err[31] ? -err : err;
  // First tick after reset has no reference spacing
  always @(posedge clock) begin
    if (reset || sample_tick)
      gap_q <= 32'h0;
    else
      gap_q <= gap_q + 32'h1;
    seen_q <= reset ? 1'b0 : (seen_q | sample_tick);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  tick_period_a: assert property (sample_tick && seen_q |->
    gap_q == SAMPLE_CYC - 1) else $error("tick spacing wrong");
  pos_hold_a: assert property (!sample_tick && !cmd_valid |=>
    $stable(pos_cmd_x)) else $error("position moved off tick");
  reject_cause_a: assert property (increment_reject[0] |->
    $past(cmd_valid && cmd_op == 4'ha && cmd_axes[0]))
    else $error("reject without increment");
  inpos_close_a: assert property (profile_done_wait[0] &&
    mag <= INPOS_TOL |-> in_position_wait[0])
    else $error("settled but not in position");
  inpos_tol_a: assert property (in_position_wait[0] |->
    profile_done_wait[0] && mag <= INPOS_TOL)
    else $error("in position outside tolerance");
  halt_rest_a: assert property (cmd_valid && cmd_op == 4'h9 &&
    cmd_axes[0] |-> ##[1:400] profile_done_wait[0])
    else $error("halt never came to rest");
  speed_on_tick_a: assert property ($rose(at_speed_wait[0]) |->
    $past(sample_tick) || $past(cmd_valid))
    else $error("at speed changed off tick");
  done_hold_a: assert property (profile_done_wait[0] && !cmd_valid
    |=> profile_done_wait[0]) else $error("done dropped alone");
endmodule // apg_checker

bind apg_axis_profile_generator apg_checker #(
  .SAMPLE_CYC(SAMPLE_CYC),
  .INPOS_TOL (INPOS_TOL)
) u_chk (
  .clock            (clock),
  .reset            (reset),
  .cmd_valid        (cmd_valid),
  .cmd_op           (cmd_op),
  .cmd_axes         (cmd_axes),
  .actual_pos_x     (actual_pos_x),
  .pos_cmd_x        (pos_cmd_x),
  .profile_done_wait(profile_done_wait),
  .in_position_wait (in_position_wait),
  .at_speed_wait    (at_speed_wait),
  .increment_reject (increment_reject),
  .sample_tick      (sample_tick)
);

// File: testbench/axis_profile_generator_tb.sv
// Self-checking bench for the two-axis profile generator
`timescale 1ns/10ps
module axis_profile_generator_tb;
  reg         clock = 1'b0;
  reg         reset = 1'b1;
  reg         cmd_valid = 1'b0;
  reg  [3:0]  cmd_op = 4'h0;
  reg  [1:0]  cmd_axes = 2'h0;
  reg  [31:0] cmd_val_x = 32'h0;
  reg  [31:0] cmd_val_y = 32'h0;
  reg         rb_axis = 1'b0;
  reg  [2:0]  rb_sel = 3'h0;
  reg  [1:0]  rej;
  reg  [31:0] p0;
  wire [31:0] vel_x, vel_y;
  wire [31:0] act_x, act_y, pos_x, pos_y, rb_data;
  wire [1:0]  done, inpos, at_speed, reject;
  integer     miscompares = 0;
  integer     n_tests = 0;
  integer     i;
  initial begin
    forever #10 clock = ~clock;
  end
  apg_axis_profile_generator #(.SAMPLE_CYC(8), .TV_SAMPLES(4)) dut (
    .clock(clock), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_axes(cmd_axes), .cmd_val_x(cmd_val_x),
    .cmd_val_y(cmd_val_y), .actual_pos_x(act_x), .actual_pos_y(act_y),
    .rb_axis(rb_axis), .rb_sel(rb_sel), .pos_cmd_x(pos_x),
    .pos_cmd_y(pos_y), .measured_velocity_x(vel_x),
    .measured_velocity_y(vel_y),
    .profile_done_wait(done), .in_position_wait(inpos),
    .at_speed_wait(at_speed), .increment_reject(reject),
    .sample_tick(), .rb_data(rb_data));
  apg_amp_model amp_x (.clock(clock), .pos_cmd(pos_x), .actual_pos(act_x));
  apg_amp_model amp_y (.clock(clock), .pos_cmd(pos_y), .actual_pos(act_y));
  task check(input string what, input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmd(input [3:0] op, input [1:0] ax, input [31:0] vx, vy);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_axes <= ax;
    cmd_val_x <= vx;
    cmd_val_y <= vy;
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task rb(input ax, input [2:0] sel, input [31:0] exp, input string what);
    @(posedge clock);
    rb_axis <= ax;
    rb_sel <= sel;
    repeat (2) @(posedge clock);
    #1 check(what, rb_data, exp);
  endtask
  // Kind 0 waits for done, 1 for at speed, 2 for in position
  task wait_for(input [1:0] mask, input [1:0] kind);
    reg [1:0] f;
    @(posedge clock);
    #1;
    for (i = 0; i < 2000; i = i + 1) begin
      f = kind == 2'h0 ? done : (kind == 2'h1 ? at_speed : inpos);
      if ((f & mask) === mask)
        i = 3000;
      else
        @(posedge clock);
    end
    if (i == 2000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
    #1;
  endtask
  // Ramp-down is left alone while an axis moves; targets still change there by increment
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1 check("done", done, 2'h3);
    cmd(4'h4, 2'h3, 32'h100, 32'h100);
    cmd(4'h5, 2'h3, 32'h100, 32'h100);
    cmd(4'h3, 2'h3, 32'h400, 32'h400);
    cmd(4'h3, 2'h1, 32'h200, 32'h0);
    rb(1'b0, 3'h2, 32'h200, "speed x");
    rb(1'b1, 3'h2, 32'h400, "speed y");
    rb(1'b1, 3'h0, 32'h100, "up y");
    rb(1'b0, 3'h1, 32'h100, "down x");
    cmd(4'h2, 2'h3, 32'h28, 32'h6);
    cmd(4'h8, 2'h0, 32'h0, 32'h0);
    @(posedge clock);
    #1 check("busy", done, 2'h0);
    wait_for(2'h3, 2'h0);
    check("pos x", pos_x, 32'h28);
    check("pos y", pos_y, 32'h6);
    rb(1'b0, 3'h3, 32'h28, "rel x");
    rb(1'b0, 3'h4, 32'h28, "stop x");
    cmd(4'h2, 2'h3, 32'h14, 32'h14);
    cmd(4'h8, 2'h1, 32'h0, 32'h0);
    @(posedge clock);
    #1 check("x only", done, 2'h2);
    wait_for(2'h3, 2'h0);
    check("pos x", pos_x, 32'h3c);
    check("pos y", pos_y, 32'h6);
    cmd(4'h2, 2'h1, 32'h28, 32'h0);
    cmd(4'h8, 2'h1, 32'h0, 32'h0);
    repeat (24) @(posedge clock);
    cmd(4'ha, 2'h1, 32'hffff_fff8, 32'h0);
    rej = reject;
    @(posedge clock);
    #1 rej = rej | reject;
    check("reject", rej, 2'h1);
    cmd(4'ha, 2'h1, 32'ha, 32'h0);
    wait_for(2'h3, 2'h0);
    check("incr x", pos_x, 32'h6e);
    cmd(4'ha, 2'h2, 32'h0, 32'h5);
    @(posedge clock);
    #1 check("idle incr", done, 2'h1);
    wait_for(2'h3, 2'h0);
    check("pos y", pos_y, 32'hb);
    cmd(4'h1, 2'h2, 32'h0, 32'h20);
    cmd(4'h8, 2'h2, 32'h0, 32'h0);
    wait_for(2'h3, 2'h0);
    check("abs y", pos_y, 32'h20);
    cmd(4'h6, 2'h2, 32'h0, 32'hffff_fe00);
    cmd(4'h8, 2'h2, 32'h0, 32'h0);
    wait_for(2'h2, 2'h1);
    cmd(4'h9, 2'h2, 32'h0, 32'h0);
    wait_for(2'h2, 2'h0);
    check("jog y back", {31'h0, pos_y < 32'h20}, 32'h1);
    cmd(4'h7, 2'h1, 32'h2, 32'h0);
    cmd(4'h2, 2'h1, 32'h12, 32'h0);
    cmd(4'h8, 2'h1, 32'h0, 32'h0);
    wait_for(2'h3, 2'h0);
    check("smooth x", pos_x, 32'h80);
    cmd(4'h2, 2'h1, 32'h190, 32'h0);
    cmd(4'h8, 2'h1, 32'h0, 32'h0);
    repeat (40) @(posedge clock);
    cmd(4'h9, 2'h1, 32'h0, 32'h0);
    wait_for(2'h1, 2'h0);
    check("halt short", {31'h0, pos_x < 32'h210}, 32'h1);
    cmd(4'h6, 2'h1, 32'h300, 32'h0);
    cmd(4'h8, 2'h1, 32'h0, 32'h0);
    wait_for(2'h1, 2'h1);
    rb(1'b0, 3'h2, 32'h300, "jog x");
    cmd(4'h6, 2'h1, 32'h100, 32'h0);
    @(posedge clock);
    #1 check("ramping", at_speed, 2'h0);
    wait_for(2'h1, 2'h1);
    // Smoothing off so one count per sample reaches the encoder
    cmd(4'h7, 2'h1, 32'h0, 32'h0);
    repeat (80) @(posedge clock);
    // Four counts per four-sample window, scaled by four
    rb(1'b0, 3'h5, 32'h10, "vel rb x");
    check("vel x", vel_x, 32'h10);
    cmd(4'ha, 2'h1, 32'h20, 32'h0);
    p0 = pos_x;
    repeat (16) @(posedge clock);
    // Jump plus one or two jog steps; a step may be lost to the jump
    #1 check("jog incr", {31'h0, (pos_x - p0 - 32'h21) <= 32'h1},
             32'h1);
    cmd(4'h9, 2'h1, 32'h0, 32'h0);
    wait_for(2'h3, 2'h0);
    wait_for(2'h3, 2'h2);
    check("vel y", vel_y, 32'h0);
    wrap_up;
  end
endmodule // axis_profile_generator_tb
